// [ucs_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ucs_map.svh"

// Contract
// - Control bit 7 gates transmit buffer empty onto interrupt.
// - Control bit 6 gates transmit done onto interrupt.
// - Control bit 5 gates receive full and overrun onto interrupt.
// - Control bit 4 gates line quiet onto interrupt.
// - Bit 3 enables transmitter, owns output pin, queues idle preamble.
// - Bit 2 enables the receiver.
// - Bit 1 is receiver standby; masks rx interrupts; hardware clears on wakeup.
// - Pulsing break bit sends one break of 10/11 or 13/14 zeros.
// - Break bit held set sends breaks back to back.
// - Status register readable anytime; writes do nothing.
// - Buffer empty sets on shift load; clears by status read, data write.
// - Transmit done low while busy; high when empty and idle.
// - Done clears by read then write, or on queueing; clear wins.
// - Receive full sets on frame move; clears by status read, data read.
// - Line quiet sets after 10 or 11 consecutive ones.
// - Quiet clears by read sequence; re-arms only after a received frame.
// - In standby, idle line does not set line quiet.
// - Control register readable and writable anytime.
// - Overrun sets on second frame; new data lost, held data kept.

module ucs_ctrl
  import ucs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_pin,
  output logic txd_out,
  output logic txd_oe,
  output logic irq
);

  logic [7:0] ctrl_reg;
  logic [7:0] cfg_reg;
  logic [8:0] tx_buf_reg;
  logic [8:0] rx_data_reg;
  logic tx_buffer_empty_flag_reg, tc_reg, rx_buffer_full_flag_reg, quiet_reg, ovr_reg;
  logic arm_tx_buffer_empty_flag_reg, arm_tc_reg, arm_rx_buffer_full_flag_reg, arm_quiet_reg, arm_ovr_reg;
  logic quiet_ok_reg;
  logic pend_pre_reg, pend_brk_reg;
  logic rx_meta_reg, rx_sync_reg;
  ucs_tx_state_e tx_state_reg;
  logic [7:0] tx_cyc_reg;
  logic [3:0] tx_cnt_reg;
  logic [3:0] tx_len_reg;
  logic [10:0] tx_sh_reg;
  logic [7:0] status;
  logic [5:0] widx;
  logic setup, access, wr, rd, mapped;
  logic wr_ctrl, wr_data, rd_stat, rd_data, wr_stat;
  logic frame_done, quiet_done;
  logic [8:0] frame_data;
  logic start_brk, start_pre, start_data, tx_start, tx_last;
  logic tc_set, tc_clr;
  logic [3:0] flen;

  // Address decode; registers sit on word boundaries
  assign widx = paddr[7:2];
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign mapped = ({2'b00, widx} == `UCS_CTRL_IDX) || ({2'b00, widx} == `UCS_STAT_IDX) ||
                  ({2'b00, widx} == `UCS_DATA_IDX) || ({2'b00, widx} == `UCS_CFG_IDX);
  assign wr_ctrl = wr && ({2'b00, widx} == `UCS_CTRL_IDX);
  assign wr_stat = wr && ({2'b00, widx} == `UCS_STAT_IDX);
  assign wr_data = wr && ({2'b00, widx} == `UCS_DATA_IDX);
  assign rd_stat = rd && ({2'b00, widx} == `UCS_STAT_IDX);
  assign rd_data = rd && ({2'b00, widx} == `UCS_DATA_IDX);

  // Zero wait states; unmapped words answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  assign status = {tx_buffer_empty_flag_reg, tc_reg, rx_buffer_full_flag_reg, quiet_reg, ovr_reg, 3'b000};

  // Read data captured in setup so it comes from flops in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
    begin
      if ({2'b00, widx} == `UCS_CTRL_IDX)
        prdata <= {24'h00_0000, ctrl_reg};
      else if ({2'b00, widx} == `UCS_STAT_IDX)
        prdata <= {24'h00_0000, status};
      else if ({2'b00, widx} == `UCS_DATA_IDX)
        prdata <= {23'h00_0000, rx_data_reg};
      else if ({2'b00, widx} == `UCS_CFG_IDX)
        prdata <= {24'h00_0000, cfg_reg};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // Control register; standby cleared by hardware on idle-line wakeup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= `UCS_CTRL_RST;
    else if (wr_ctrl)
      ctrl_reg <= pwdata[7:0];
    else if (ctrl_reg[`UCS_RX_STBY] && quiet_done)
      ctrl_reg[`UCS_RX_STBY] <= 1'b0;
  end

  // Frame format register: 9-bit mode, long break, ninth tx bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_reg <= `UCS_CFG_RST;
    else if (wr && ({2'b00, widx} == `UCS_CFG_IDX))
      cfg_reg <= {5'h00, pwdata[2:0]};
  end

  // Transmit buffer; written data waits here until the shifter takes it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_buf_reg <= 9'h000;
    else if (wr_data)
      tx_buf_reg <= {cfg_reg[`UCS_CFG_TX_B8], pwdata[7:0]};
  end

  // Clear arming: a status read remembers which flags it returned set.
  // Armed from the captured read data, so a flag rising after setup stays unarmed.
  // Arms survive unrelated accesses, so other code may run between.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {arm_tx_buffer_empty_flag_reg, arm_tc_reg} <= 2'b00;
      {arm_rx_buffer_full_flag_reg, arm_quiet_reg, arm_ovr_reg} <= 3'b000;
    end
    else if (rd_stat)
    begin
      {arm_tx_buffer_empty_flag_reg, arm_tc_reg} <= prdata[7:6];
      {arm_rx_buffer_full_flag_reg, arm_quiet_reg, arm_ovr_reg} <= prdata[5:3];
    end
    else
    begin
      if (wr_data)
        {arm_tx_buffer_empty_flag_reg, arm_tc_reg} <= 2'b00;
      if (rd_data)
        {arm_rx_buffer_full_flag_reg, arm_quiet_reg, arm_ovr_reg} <= 3'b000;
    end
  end

  // Queued preamble on transmitter enable, queued break on break bit set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_pre_reg <= 1'b0;
      pend_brk_reg <= 1'b0;
    end
    else
    begin
      if (wr_ctrl && pwdata[`UCS_TX_ON] && !ctrl_reg[`UCS_TX_ON])
        pend_pre_reg <= 1'b1;
      else if (start_pre)
        pend_pre_reg <= 1'b0;
      // Latched so a set then early clear still yields one break
      if (wr_ctrl && pwdata[`UCS_BRK_SEND] && !ctrl_reg[`UCS_BRK_SEND])
        pend_brk_reg <= 1'b1;
      else if (start_brk)
        pend_brk_reg <= 1'b0;
    end
  end

  // Next job from idle: break first, then preamble, then data
  assign flen = ucs_frame_bits(cfg_reg[`UCS_CFG_NINE]);
  assign start_brk = (tx_state_reg == UCS_TX_IDLE) && ctrl_reg[`UCS_TX_ON] &&
                     (pend_brk_reg || ctrl_reg[`UCS_BRK_SEND]);
  assign start_pre = (tx_state_reg == UCS_TX_IDLE) && ctrl_reg[`UCS_TX_ON] &&
                     !start_brk && pend_pre_reg;
  assign start_data = (tx_state_reg == UCS_TX_IDLE) && ctrl_reg[`UCS_TX_ON] &&
                      !start_brk && !pend_pre_reg && !tx_buffer_empty_flag_reg;
  assign tx_start = start_brk || start_pre || start_data;
  assign tx_last = (tx_cyc_reg == 8'h00) && (tx_cnt_reg == tx_len_reg - 4'h1);

  // Transmit shifter; every job is a run of bits shifted out LSB first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_reg <= UCS_TX_IDLE;
      tx_cyc_reg <= 8'h00;
      tx_cnt_reg <= 4'h0;
      tx_len_reg <= 4'h0;
      tx_sh_reg <= 11'h7ff;
    end
    else
    begin
      unique case (tx_state_reg)
        UCS_TX_IDLE:
        begin
          tx_sh_reg <= 11'h7ff;
          tx_cyc_reg <= `UCS_BIT_CYCLES - 8'h01;
          tx_cnt_reg <= 4'h0;
          if (start_brk)
          begin
            tx_state_reg <= UCS_TX_BRK;
            tx_sh_reg <= 11'h000;
            tx_len_reg <= cfg_reg[`UCS_CFG_LONG_BRK] ?
                          flen + `UCS_LONG_BRK_EXTRA : flen;
          end
          else if (start_pre)
          begin
            tx_state_reg <= UCS_TX_PRE;
            tx_len_reg <= flen;
          end
          else if (start_data)
          begin
            tx_state_reg <= UCS_TX_DATA;
            tx_len_reg <= flen;
            tx_sh_reg <= cfg_reg[`UCS_CFG_NINE] ? {1'b1, tx_buf_reg, 1'b0} :
                                                  {2'b11, tx_buf_reg[7:0], 1'b0};
          end
        end
        UCS_TX_DATA, UCS_TX_PRE, UCS_TX_BRK:
        begin
          if (tx_last)
            tx_state_reg <= UCS_TX_IDLE;
          else if (tx_cyc_reg == 8'h00)
          begin
            tx_cyc_reg <= `UCS_BIT_CYCLES - 8'h01;
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            tx_sh_reg <= {(tx_state_reg != UCS_TX_BRK), tx_sh_reg[10:1]};
          end
          else
            tx_cyc_reg <= tx_cyc_reg - 8'h01;
        end
        default:
          tx_state_reg <= UCS_TX_IDLE;
      endcase
    end
  end

  // Pin idles high; enable follows the transmitter enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txd_out <= 1'b1;
      txd_oe <= 1'b0;
    end
    else
    begin
      txd_out <= (tx_state_reg == UCS_TX_IDLE) ? 1'b1 : tx_sh_reg[0];
      txd_oe <= ctrl_reg[`UCS_TX_ON];
    end
  end

  // Buffer empty: set on shifter load; a data write clears it only
  // after an arming status read, and the load wins any collision
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_buffer_empty_flag_reg <= 1'b1;
    else if (start_data)
      tx_buffer_empty_flag_reg <= 1'b1;
    else if (wr_data && arm_tx_buffer_empty_flag_reg)
      tx_buffer_empty_flag_reg <= 1'b0;
  end

  // Transmit done: clearing wins over setting in the same cycle
  assign tc_set = tx_buffer_empty_flag_reg && (tx_state_reg == UCS_TX_IDLE) && !pend_pre_reg &&
                  !pend_brk_reg && !ctrl_reg[`UCS_BRK_SEND];
  assign tc_clr = (wr_data && arm_tc_reg) || tx_start ||
                  (tx_state_reg != UCS_TX_IDLE) ||
                  (wr_ctrl && pwdata[`UCS_BRK_SEND]) ||
                  (wr_ctrl && pwdata[`UCS_TX_ON] && !ctrl_reg[`UCS_TX_ON]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tc_reg <= 1'b1;
    else if (tc_clr)
      tc_reg <= 1'b0;
    else if (tc_set)
      tc_reg <= 1'b1;
  end

  // Two-flop synchroniser for the serial input pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= rxd_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  ucs_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .rxd(rx_sync_reg),
    .enable(ctrl_reg[`UCS_RX_ON]),
    .nine_bit(cfg_reg[`UCS_CFG_NINE]),
    .frame_done(frame_done),
    .frame_data(frame_data),
    .quiet_done(quiet_done)
  );

  // Receive full and overrun; a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_buffer_full_flag_reg <= 1'b0;
      ovr_reg <= 1'b0;
      rx_data_reg <= 9'h000;
    end
    else
    begin
      if (frame_done && rx_buffer_full_flag_reg && !(rd_data && arm_rx_buffer_full_flag_reg))
        ovr_reg <= 1'b1;
      else if (rd_data && arm_ovr_reg)
        ovr_reg <= 1'b0;
      if (frame_done && (!rx_buffer_full_flag_reg || (rd_data && arm_rx_buffer_full_flag_reg)))
      begin
        rx_buffer_full_flag_reg <= 1'b1;
        rx_data_reg <= frame_data;
      end
      else if (rd_data && arm_rx_buffer_full_flag_reg)
        rx_buffer_full_flag_reg <= 1'b0;
    end
  end

  // Line quiet; re-armed only by a frame landing in the buffer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quiet_reg <= 1'b0;
      quiet_ok_reg <= 1'b1;
    end
    else
    begin
      if (quiet_done && quiet_ok_reg && !ctrl_reg[`UCS_RX_STBY])
        quiet_reg <= 1'b1;
      else if (rd_data && arm_quiet_reg)
      begin
        quiet_reg <= 1'b0;
        quiet_ok_reg <= 1'b0;
      end
      if (frame_done && (!rx_buffer_full_flag_reg || (rd_data && arm_rx_buffer_full_flag_reg)))
        quiet_ok_reg <= 1'b1;
    end
  end

  // Single request; receiver sources masked during standby
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= (tx_buffer_empty_flag_reg && ctrl_reg[`UCS_TX_EMPTY_IE]) ||
             (tc_reg && ctrl_reg[`UCS_TX_DONE_IE]) ||
             (!ctrl_reg[`UCS_RX_STBY] &&
              (((rx_buffer_full_flag_reg || ovr_reg) && ctrl_reg[`UCS_RX_FULL_IE]) ||
               (quiet_reg && ctrl_reg[`UCS_QUIET_IE])));
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_armed_write;
    arm_tx_buffer_empty_flag_reg && wr_data && !start_data;
  endsequence

  sequence seq_second_frame;
    frame_done && rx_buffer_full_flag_reg && !rd_data;
  endsequence

  chk_irq_tx_empty: assert property (tx_buffer_empty_flag_reg && ctrl_reg[7] |=> irq)
    else $error("tx empty request missing");
  chk_irq_all_off: assert property (ctrl_reg[7:4] == 4'h0 |=> !irq)
    else $error("request raised with all enables off");
  chk_irq_standby: assert property (ctrl_reg[7:6] == 2'b00 && ctrl_reg[1] |=> !irq)
    else $error("receiver request during standby");
  chk_stat_write_none: assert property (wr_stat && !tx_start |=>
    ($past(status) & ~status) == 8'h00)
    else $error("status write changed flags");
  chk_tx_buffer_empty_flag_clear: assert property (seq_armed_write |=> !tx_buffer_empty_flag_reg)
    else $error("buffer empty flag did not clear");
  chk_tc_busy_low: assert property (tx_state_reg != UCS_TX_IDLE |-> !tc_reg)
    else $error("done flag high while sending");
  chk_rx_buffer_full_flag_load: assert property (frame_done && !rx_buffer_full_flag_reg |=>
    rx_buffer_full_flag_reg && rx_data_reg == $past(frame_data))
    else $error("receive full did not load");
  chk_overrun_keep: assert property (seq_second_frame |=> ovr_reg && $stable(rx_data_reg))
    else $error("overrun lost held data");
  chk_quiet_standby: assert property (ctrl_reg[1] && !quiet_reg |=> !quiet_reg)
    else $error("quiet flag set in standby");
  chk_break_zero: assert property (tx_state_reg == UCS_TX_BRK |=> txd_out == 1'b0)
    else $error("break bit not low on the pin");

endmodule : ucs_ctrl
`default_nettype wire

// [ucs_map.svh]
`ifndef UCS_MAP_SVH
`define UCS_MAP_SVH

// Register indices; byte address is four times the index
`define UCS_CTRL_IDX 8'h03
`define UCS_STAT_IDX 8'h04
`define UCS_DATA_IDX 8'h07
`define UCS_CFG_IDX 8'h08

// Control register fields
`define UCS_TX_EMPTY_IE 7
`define UCS_TX_DONE_IE 6
`define UCS_RX_FULL_IE 5
`define UCS_QUIET_IE 4
`define UCS_TX_ON 3
`define UCS_RX_ON 2
`define UCS_RX_STBY 1
`define UCS_BRK_SEND 0

// Status register fields
`define UCS_ST_TX_BUFFER_EMPTY_FLAG 7
`define UCS_ST_TC 6
`define UCS_ST_RX_BUFFER_FULL_FLAG 5
`define UCS_ST_QUIET 4
`define UCS_ST_OVR 3

// Configuration register fields
`define UCS_CFG_NINE 0
`define UCS_CFG_LONG_BRK 1
`define UCS_CFG_TX_B8 2

// Reset values
`define UCS_CTRL_RST 8'h00
`define UCS_CFG_RST 8'h00

// Clock cycles per serial bit and extra break bits in long mode
`define UCS_BIT_CYCLES 8'h10
`define UCS_LONG_BRK_EXTRA 4'h3

`endif

// [ucs_pkg.sv]
package ucs_pkg;

  typedef enum logic [3:0] {
    UCS_TX_IDLE = 4'b0001,
    UCS_TX_DATA = 4'b0010,
    UCS_TX_PRE = 4'b0100,
    UCS_TX_BRK = 4'b1000
  } ucs_tx_state_e;

  typedef enum logic [1:0] {
    UCS_RX_IDLE = 2'b01,
    UCS_RX_BITS = 2'b10
  } ucs_rx_state_e;

  // Bits in one frame: start, 8 or 9 data, stop
  function automatic logic [3:0] ucs_frame_bits(input logic nine);
    ucs_frame_bits = nine ? 4'hb : 4'ha;
  endfunction : ucs_frame_bits

endpackage : ucs_pkg

// [ucs_rx.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ucs_map.svh"

module ucs_rx
  import ucs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rxd,
  input wire logic enable,
  input wire logic nine_bit,
  output logic frame_done,
  output logic [8:0] frame_data,
  output logic quiet_done
);

  ucs_rx_state_e state_reg;
  logic [7:0] cyc_reg;
  logic [3:0] idx_reg;
  logic [10:0] sh_reg;
  logic [7:0] ones_reg;
  logic [3:0] len;
  logic [7:0] quiet_lim;
  logic tick;

  assign len = ucs_frame_bits(nine_bit);
  assign quiet_lim = 8'(len * `UCS_BIT_CYCLES);
  assign tick = (cyc_reg == 8'h00);

  // Start edge, mid-bit sampling, frame assembly
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= UCS_RX_IDLE;
      cyc_reg <= 8'h00;
      idx_reg <= 4'h0;
      sh_reg <= 11'h000;
      frame_done <= 1'b0;
      frame_data <= 9'h000;
    end
    else
    begin
      frame_done <= 1'b0;
      if (!enable)
        state_reg <= UCS_RX_IDLE;
      else
        unique case (state_reg)
          UCS_RX_IDLE:
            if (!rxd)
            begin
              state_reg <= UCS_RX_BITS;
              cyc_reg <= `UCS_BIT_CYCLES >> 1; // Aim at bit centre
              idx_reg <= 4'h0;
            end
          UCS_RX_BITS:
            if (!tick)
              cyc_reg <= cyc_reg - 8'h01;
            else if (idx_reg == 4'h0 && rxd)
              state_reg <= UCS_RX_IDLE; // Glitch, not a start bit
            else
            begin
              sh_reg <= {rxd, sh_reg[10:1]};
              cyc_reg <= `UCS_BIT_CYCLES - 8'h01;
              idx_reg <= idx_reg + 4'h1;
              if (idx_reg == len - 4'h1)
              begin
                state_reg <= UCS_RX_IDLE;
                frame_done <= 1'b1;
                frame_data <= nine_bit ? sh_reg[10:2] : {1'b0, sh_reg[10:3]};
              end
            end
        endcase
    end
  end

  // Line-quiet timer; one pulse per run of ones one frame long
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ones_reg <= 8'h00;
      quiet_done <= 1'b0;
    end
    else
    begin
      quiet_done <= 1'b0;
      if (!enable || !rxd)
        ones_reg <= 8'h00;
      else if (ones_reg < quiet_lim)
      begin
        ones_reg <= ones_reg + 8'h01;
        quiet_done <= (ones_reg == quiet_lim - 8'h01);
      end
    end
  end

endmodule : ucs_rx
`default_nettype wire

// [ucs_remote_node.sv]
`timescale 1ns/1ps
`default_nettype none

// Remote serial node: drives our receive line, decodes our transmit line
module ucs_remote_node #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic pclk,
  input wire logic txd,
  input wire logic txd_oe,
  output logic rxd,
  output logic [7:0] rx_byte,
  output int low_run,
  output int n_runs
);
  logic line;
  logic [7:0] sh;
  int cur;
  int cnt;

  // Released pin floats high through the pull-up
  assign line = txd_oe ? txd : 1'b1;

  // Idle line and cleared counters at start
  initial
  begin
    rxd = 1'b1;
    rx_byte = 8'h00;
    low_run = 0;
    n_runs = 0;
    cur = 0;
    cnt = 0;
  end

  // Length of each low run, to time break characters
  always @(posedge pclk)
  begin
    if (!line)
      cur <= cur + 1;
    else if (cur != 0)
    begin
      low_run <= cur;
      n_runs <= n_runs + 1;
      cur <= 0;
    end
  end

  // Mid-bit sampling, LSB first; a break decodes as zero and is stored in rx_byte
  always @(posedge pclk)
  begin
    if (cnt == 0)
    begin
      if (!line)
        cnt <= 1;
    end
    else
    begin
      cnt <= (cnt == 9 * BIT_CYCLES + 8) ? 0 : cnt + 1;
      if (cnt % BIT_CYCLES == 8 && cnt > BIT_CYCLES && cnt < 9 * BIT_CYCLES)
        sh[cnt / BIT_CYCLES - 1] <= line;
      if (cnt == 9 * BIT_CYCLES + 8)
        rx_byte <= sh;
    end
  end

  // One frame: start, eight data bits LSB first, stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge pclk);
      rxd <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge pclk);
    end
  endtask : send

  // Short low pulse that the receiver must reject as a false start
  task automatic glitch(input int n);
    @(posedge pclk);
    rxd <= 1'b0;
    repeat (n) @(posedge pclk);
    rxd <= 1'b1;
  endtask : glitch
endmodule : ucs_remote_node

`default_nettype wire

// [tb_uart_control_status_flags.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ucs_map.svh"

module tb_uart_control_status_flags
  import ucs_pkg::*;
;
  localparam logic [7:0] A_CTRL = `UCS_CTRL_IDX << 2;
  localparam logic [7:0] A_STAT = `UCS_STAT_IDX << 2;
  localparam logic [7:0] A_DATA = `UCS_DATA_IDX << 2;
  localparam logic [7:0] A_CFG = `UCS_CFG_IDX << 2;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, rxd, txd_out, txd_oe, irq, er;
  logic [7:0] paddr, b, rx_byte;
  logic [31:0] pwdata, prdata, rd;
  int low_run, n_runs, n0;
  int n_fail = 0;
  int checked = 0;

  always #20 pclk = ~pclk;

  ucs_ctrl uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_pin(rxd), .txd_out(txd_out),
    .txd_oe(txd_oe), .irq(irq));

  ucs_remote_node rn (.pclk(pclk), .txd(txd_out), .txd_oe(txd_oe), .rxd(rxd),
    .rx_byte(rx_byte), .low_run(low_run), .n_runs(n_runs));

  // Comparison and verdict
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      check("pready", 0, 1);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
    input string nm);
    apb(1'b0, a, 32'h0000_0000);
    check(nm, rd & m, e);
  endtask : rdm

  // Polls until transmit done returns; bounded so a stuck flag cannot hang
  task automatic wait_tc();
    int n;
    n = 0;
    do
    begin
      repeat (10) @(posedge pclk);
      apb(1'b0, A_STAT, 32'h0000_0000);
      n++;
    end
    while (rd[`UCS_ST_TC] !== 1'b1 && n < 200);
    check("tc_wait", n < 200, 1);
  endtask : wait_tc

  // Expected request from enables and flags; standby masks receiver sources
  function automatic logic exp_irq(input logic [7:0] c, input logic [7:0] s);
    logic [3:0] src;
    src = {s[7], s[6], s[5] | s[3], s[4]};
    if (c[`UCS_RX_STBY])
      src[1:0] = 2'b00;
    return |(c[7:4] & src);
  endfunction : exp_irq

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    void'($urandom(82));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdm(A_CTRL, 8'hFF, `UCS_CTRL_RST, "ctrl_rst");
    rdm(A_STAT, 8'hFF, 8'hC0, "stat_rst");
    // Random enables: read back, and transmit flags gated onto irq
    repeat (6)
    begin
      b = 8'($urandom) & 8'hF0;
      wr(A_CTRL, b);
      rdm(A_CTRL, 8'hFF, b, "ctrl_rw");
      check("irq_tx", irq, exp_irq(b, 8'hC0));
    end
    wr(A_CTRL, 8'h00);
    wr(A_STAT, 32'hFFFF_FFFF);
    rdm(A_STAT, 8'hFF, 8'hC0, "stat_ro");
    apb(1'b0, 8'h3C, 32'h0000_0000);
    check("bad_err", er, 1);
    check("bad_rd", rd, 0);
    // Transmit: preamble, then a byte after an arming status read
    wr(A_CTRL, 8'h08);
    repeat (2) @(posedge pclk); // Enable reaches the pin one edge after the register
    check("tx_oe", txd_oe, 1);
    b = 8'($urandom);
    apb(1'b0, A_STAT, 32'h0000_0000);
    wr(A_DATA, b);
    rdm(A_STAT, 8'h40, 8'h00, "tc_busy");
    wait_tc();
    check("tx_byte", rx_byte, b);
    check("tx_idle", txd_out, 1);
    // Single break, short then long
    for (int l = 0; l < 2; l++)
    begin
      n0 = n_runs;
      wr(A_CFG, l << 1);
      wr(A_CTRL, 8'h09);
      rdm(A_STAT, 8'h40, 8'h00, "tc_brk");
      wr(A_CTRL, 8'h08);
      wait_tc();
      check("brk_len", low_run, (l ? 13 : 10) * `UCS_BIT_CYCLES);
      check("brk_once", n_runs - n0, 1);
    end
    n0 = n_runs;
    wr(A_CTRL, 8'h09);
    repeat (500) @(posedge pclk);
    wr(A_CTRL, 8'h08);
    wait_tc();
    check("brk_rep", n_runs - n0 >= 2, 1);
    // Receive: second unread frame overruns, held data kept
    wr(A_CTRL, 8'h24);
    b = 8'($urandom);
    rn.send(b);
    rn.send(~b);
    repeat (300) @(posedge pclk);
    rdm(A_STAT, 8'h38, 8'h38, "rx_stat");
    check("irq_rx", irq, exp_irq(8'h24, 8'hF8));
    wr(A_CTRL, 8'h04);
    repeat (3) @(posedge pclk);
    check("irq_rx_off", irq, exp_irq(8'h04, 8'hF8));
    rdm(A_DATA, 8'hFF, b, "rx_held");
    rdm(A_STAT, 8'h38, 8'h00, "rx_clr");
    rn.glitch(4); // False start restarts the idle timer
    repeat (400) @(posedge pclk);
    rdm(A_STAT, 8'h10, 8'h00, "quiet_hold");
    b = 8'($urandom);
    rn.send(b);
    repeat (300) @(posedge pclk);
    rdm(A_STAT, 8'h30, 8'h30, "rx_rearm");
    wr(A_CTRL, 8'h14);
    repeat (3) @(posedge pclk);
    check("irq_quiet", irq, exp_irq(8'h14, 8'hF0));
    rdm(A_DATA, 8'hFF, b, "rx_data");
    // Standby: receiver requests masked; idle line wakes without the quiet flag
    wr(A_CTRL, 8'h36);
    b = 8'($urandom) & 8'h7F; // Top bit low so the idle run starts at the stop bit
    rn.send(b);
    repeat (20) @(posedge pclk);
    check("irq_stby", irq, 0);
    repeat (300) @(posedge pclk);
    rdm(A_CTRL, 8'hFF, 8'h34, "stby_wake");
    rdm(A_STAT, 8'h30, 8'h20, "quiet_stby");
    check("irq_wake", irq, exp_irq(8'h34, 8'hE0));
    give_verdict();
  end

  // Watchdog, well past the expected run length
  initial
  begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end
endmodule : tb_uart_control_status_flags

`default_nettype wire
